// [verilog/pixfmt_pkg.sv]
`default_nettype none
package pixfmt_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int SENSOR_W  = 32;
  localparam int SENSOR_H  = 32;
  localparam int COL_BITS  = 5;
  localparam int ROW_BITS  = 5;
  localparam int ADDR_BITS = 10;
  localparam int DIM_BITS  = 6;
  localparam int NUM_COEF  = 12;
  localparam int FRAC_BITS = 6;
  localparam logic [ADDR_BITS-1:0] LAST_PIXEL = 10'h3ff;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_COL_START    = 8'h04;
  localparam logic [7:0] REG_ROW_START    = 8'h08;
  localparam logic [7:0] REG_WIN_WIDTH    = 8'h0c;
  localparam logic [7:0] REG_WIN_HEIGHT   = 8'h10;
  localparam logic [7:0] REG_HMERGE       = 8'h14;
  localparam logic [7:0] REG_VMERGE       = 8'h18;
  localparam logic [7:0] REG_MERGE_MODE   = 8'h1c;
  localparam logic [7:0] REG_HSKIP        = 8'h20;
  localparam logic [7:0] REG_VSKIP        = 8'h24;
  localparam logic [7:0] REG_MIRROR       = 8'h28;
  localparam logic [7:0] REG_COEF_PICK    = 8'h2c;
  localparam logic [7:0] REG_COEF_VALUE   = 8'h30;
  localparam logic [7:0] REG_STATUS       = 8'h34;

  // CTRL fields
  localparam int CTRL_HALT_BIT  = 0;
  localparam int CTRL_TEST_BIT  = 1;
  localparam int CTRL_MAT_BIT   = 2;
  localparam int CTRL_SRC_BIT   = 3;
  localparam int CTRL_FMT_POS   = 4;
  localparam int CTRL_GAMMA_POS = 6;
  // STATUS fields
  localparam int STAT_KIND_POS  = 0;
  localparam int STAT_BUSY_BIT  = 4;
  localparam int STAT_W_POS     = 8;
  localparam int STAT_H_POS     = 16;

  localparam logic [1:0] GAMMA_ONE    = 2'h0;
  localparam logic [1:0] GAMMA_DARK   = 2'h1;
  localparam logic [1:0] GAMMA_BRIGHT = 2'h2;
  localparam logic [1:0] KIND_USER         = 2'h0;
  localparam logic [1:0] KIND_LUMA_CHROMA  = 2'h1;
  localparam logic [1:0] KIND_LUMA_ONLY    = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FMT_RGB, FMT_YUV, FMT_YCBCR, FMT_MONO} fmt_t;
  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_DRAIN} state_t;
  typedef logic [2:0][7:0]  rgb_t;       // [2]=red [1]=green [0]=blue
  typedef logic [11:0][8:0] coef_set_t;  // 0..8 gains row-major, 9..11 offsets

  typedef struct packed {
    logic                valid;
    logic                sof;
    rgb_t                data;
  } in_pix_t;

  typedef struct packed {
    logic                valid;
    logic                sof;
    logic                eol;
    logic                eof;
    rgb_t                data;
  } out_pix_t;

  typedef struct packed {
    logic [1:0]          gamma;
    logic                mat_en;
    logic                coef_src;
    fmt_t                fmt;
    logic                test_en;
    logic [COL_BITS-1:0] col_start;
    logic [ROW_BITS-1:0] row_start;
    logic [DIM_BITS-1:0] win_w;
    logic [DIM_BITS-1:0] win_h;
    logic [1:0]          hbin_sh;
    logic [1:0]          vbin_sh;
    logic [1:0]          hskip_sh;
    logic [1:0]          vskip_sh;
    logic                hmode_avg;
    logic                vmode_avg;
    logic                mirror_columns;
    logic                mirror_rows;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{gamma: GAMMA_ONE, mat_en: 1'b0,
    coef_src: 1'b0, fmt: FMT_RGB, test_en: 1'b0, col_start: 5'h00,
    row_start: 5'h00, win_w: 6'h20, win_h: 6'h20, hbin_sh: 2'h0,
    vbin_sh: 2'h0, hskip_sh: 2'h0, vskip_sh: 2'h0, hmode_avg: 1'b0,
    vmode_avg: 1'b0, mirror_columns: 1'b0, mirror_rows: 1'b0};

  // Gains carry FRAC_BITS fraction bits, so 9'h040 is unity
  localparam coef_set_t COEF_IDENTITY = {9'h000, 9'h000, 9'h000,
    9'h040, 9'h000, 9'h000, 9'h000, 9'h040, 9'h000, 9'h000, 9'h000, 9'h040};
  localparam coef_set_t COEF_CORRECTION = {9'h000, 9'h000, 9'h000,
    9'h050, 9'h1f8, 9'h1f8, 9'h1f8, 9'h050, 9'h1f8, 9'h1f8, 9'h1f8, 9'h050};
  localparam coef_set_t COEF_LUMA_CHROMA = {9'h080, 9'h080, 9'h000,
    9'h1fb, 9'h1e5, 9'h020, 9'h020, 9'h1eb, 9'h1f5, 9'h007, 9'h026, 9'h013};
  localparam coef_set_t COEF_LUMA_ONLY = {9'h000, 9'h000, 9'h000,
    9'h007, 9'h026, 9'h013, 9'h007, 9'h026, 9'h013, 9'h007, 9'h026, 9'h013};
endpackage
`default_nettype wire

// [verilog/gamma_curve.sv]
`timescale 1ns/100ps
`default_nettype none
module gamma_curve (
  input  wire logic [1:0]        mode,
  input  wire pixfmt_pkg::rgb_t  px_in,
  output var  pixfmt_pkg::rgb_t  px_out
);
  import pixfmt_pkg::*;

  genvar k;
  generate
    for (k = 0; k < 3; k++)
    begin : g_comp
      logic [15:0] sq;
      logic [8:0]  bright;
      assign sq     = px_in[k] * px_in[k];
      // x*x darkens, 2x - x*x brightens; both keep 0, only brightening keeps full scale (dark maps 8'hff to 8'hfe)
      assign bright = {px_in[k], 1'b0} - {1'b0, sq[15:8]};
      always_comb
      begin
        if (mode == GAMMA_DARK)
          px_out[k] = sq[15:8];
        else if (mode == GAMMA_BRIGHT)
          px_out[k] = bright[8] ? 8'hff : bright[7:0];
        else
          px_out[k] = px_in[k];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [verilog/color_matrix.sv]
`timescale 1ns/100ps
`default_nettype none
module color_matrix (
  input  wire pixfmt_pkg::rgb_t      px_in,
  input  wire pixfmt_pkg::coef_set_t coef,
  output var  pixfmt_pkg::rgb_t      px_out
);
  import pixfmt_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_row
      logic signed [19:0] prod_sum;
      logic signed [19:0] total;
      // Output row i is stored in component 2-i (red first)
      assign prod_sum =
        20'($signed(coef[3*i])   * $signed({1'b0, px_in[2]})) +
        20'($signed(coef[3*i+1]) * $signed({1'b0, px_in[1]})) +
        20'($signed(coef[3*i+2]) * $signed({1'b0, px_in[0]}));
      assign total = (prod_sum >>> FRAC_BITS)
                   + 20'($signed(coef[9+i]));
      always_comb
      begin
        if (total < 0)
          px_out[2-i] = 8'h00;
        else if (total > 20'sh000ff)
          px_out[2-i] = 8'hff;
        else
          px_out[2-i] = total[7:0];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [verilog/pixel_format_pipeline.sv]
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module pixel_format_pipeline (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  logic [31:0]          reg_rdata,
  input  wire pixfmt_pkg::in_pix_t  pix_in,
  output var  logic                 in_ready,
  output var  pixfmt_pkg::out_pix_t pix_out
);
  import pixfmt_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cfg_t                shd_q;
  cfg_t                act_q;
  cfg_t                cfg_use;
  logic                halt_q;
  coef_set_t           ucoef_q;
  coef_set_t           eff_coef;
  coef_set_t           act_coef_q;
  coef_set_t           coef_use;
  logic [3:0]          pick_q;
  logic [1:0]          kind;
  logic                fac_ok;
  logic [1:0]          fac_sh;
  logic [DIM_BITS-1:0] shd_w;
  logic [DIM_BITS-1:0] shd_h;
  logic [31:0]         rdata_q;
  state_t              st_q;
  state_t              st_d;
  logic                in_ready_q;
  logic                take;
  logic                start;
  logic [ADDR_BITS-1:0] wr_idx_q;
  logic [ADDR_BITS-1:0] wr_addr;
  rgb_t                gam;
  rgb_t                mat;
  rgb_t                proc;
  rgb_t                mem [0:SENSOR_W*SENSOR_H-1];
  logic [DIM_BITS-1:0] out_w;
  logic [DIM_BITS-1:0] out_h;
  logic [DIM_BITS-1:0] oc_q;
  logic [DIM_BITS-1:0] orow_q;
  logic [1:0]          bx_q;
  logic [1:0]          by_q;
  logic                bx_last;
  logic                by_last;
  logic                px_done;
  logic                oc_last;
  logic                row_last;
  logic [DIM_BITS-1:0] col_base;
  logic [DIM_BITS-1:0] row_base;
  logic [DIM_BITS-1:0] src_col;
  logic [DIM_BITS-1:0] src_row;
  rgb_t                smp;
  logic [2:0][11:0]    acc_q;
  logic [2:0][11:0]    tot;
  logic [2:0]          avg_sh;
  rgb_t                res;
  rgb_t                pattern;
  out_pix_t            out_q;

  assign reg_rdata = rdata_q;
  assign in_ready  = in_ready_q;
  assign pix_out   = out_q;

  // Factor 1, 2 or 4 as a shift; others are refused
  function automatic logic [1:0] bin_last(input logic [1:0] sh);
    bin_last = (sh == 2'h0) ? 2'h0 : ((sh == 2'h1) ? 2'h1 : 2'h3);
  endfunction

  always_comb
  begin
    fac_ok = 1'b1;
    fac_sh = 2'h0;
    case (reg_wdata)
      32'h0000_0001: fac_sh = 2'h0;
      32'h0000_0002: fac_sh = 2'h1;
      32'h0000_0004: fac_sh = 2'h2;
      default:       fac_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Software settings (shadow copy)
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shd_q  <= CFG_RESET;
      halt_q <= 1'b1;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:
        begin
          halt_q         <= reg_wdata[CTRL_HALT_BIT];
          shd_q.test_en  <= reg_wdata[CTRL_TEST_BIT];
          shd_q.mat_en   <= reg_wdata[CTRL_MAT_BIT];
          shd_q.coef_src <= reg_wdata[CTRL_SRC_BIT];
          shd_q.fmt      <= fmt_t'(reg_wdata[CTRL_FMT_POS +: 2]);
          shd_q.gamma    <= reg_wdata[CTRL_GAMMA_POS +: 2];
        end
        REG_COL_START:  shd_q.col_start <= reg_wdata[COL_BITS-1:0];
        REG_ROW_START:  shd_q.row_start <= reg_wdata[ROW_BITS-1:0];
        REG_WIN_WIDTH:  shd_q.win_w     <= reg_wdata[DIM_BITS-1:0];
        REG_WIN_HEIGHT: shd_q.win_h     <= reg_wdata[DIM_BITS-1:0];
        REG_HMERGE:
          if (fac_ok && (fac_sh == 2'h0 || shd_q.hskip_sh == 2'h0))
            shd_q.hbin_sh <= fac_sh;
        REG_VMERGE:
          if (fac_ok && (fac_sh == 2'h0 || shd_q.vskip_sh == 2'h0))
            shd_q.vbin_sh <= fac_sh;
        REG_HSKIP:
          if (fac_ok && (fac_sh == 2'h0 || shd_q.hbin_sh == 2'h0))
            shd_q.hskip_sh <= fac_sh;
        REG_VSKIP:
          if (fac_ok && (fac_sh == 2'h0 || shd_q.vbin_sh == 2'h0))
            shd_q.vskip_sh <= fac_sh;
        REG_MERGE_MODE:
        begin
          shd_q.hmode_avg <= reg_wdata[0];
          shd_q.vmode_avg <= reg_wdata[1];
        end
        REG_MIRROR:
        begin
          shd_q.mirror_columns <= reg_wdata[0];
          shd_q.mirror_rows    <= reg_wdata[1];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Coefficients
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ucoef_q <= COEF_IDENTITY;
      pick_q  <= 4'h0;
    end
    else if (reg_wr && reg_addr == REG_COEF_PICK)
    begin
      if (reg_wdata < 32'(NUM_COEF))
        pick_q <= reg_wdata[3:0];
    end
    else if (reg_wr && reg_addr == REG_COEF_VALUE)
    begin
      if (shd_q.fmt == FMT_RGB)
        ucoef_q[pick_q] <= reg_wdata[8:0];
    end
  end

  always_comb
  begin
    kind     = KIND_USER;
    eff_coef = shd_q.coef_src ? COEF_CORRECTION : ucoef_q;
    if (shd_q.fmt == FMT_YUV || shd_q.fmt == FMT_YCBCR)
    begin
      kind     = KIND_LUMA_CHROMA;
      eff_coef = COEF_LUMA_CHROMA;
    end
    else if (shd_q.fmt == FMT_MONO)
    begin
      kind     = KIND_LUMA_ONLY;
      eff_coef = COEF_LUMA_ONLY;
    end
  end

  // Reported size follows the settings as soon as they are written
  assign shd_w = shd_q.win_w >> (shd_q.hbin_sh + shd_q.hskip_sh);
  assign shd_h = shd_q.win_h >> (shd_q.vbin_sh + shd_q.vskip_sh);

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (reg_rd)
    begin
      rdata_q <= 32'h0000_0000;
      case (reg_addr)
        REG_CTRL:
        begin
          rdata_q[CTRL_HALT_BIT]        <= halt_q;
          rdata_q[CTRL_TEST_BIT]        <= shd_q.test_en;
          rdata_q[CTRL_MAT_BIT]         <= shd_q.mat_en;
          rdata_q[CTRL_SRC_BIT]         <= shd_q.coef_src;
          rdata_q[CTRL_FMT_POS +: 2]    <= shd_q.fmt;
          rdata_q[CTRL_GAMMA_POS +: 2]  <= shd_q.gamma;
        end
        REG_COL_START:  rdata_q[COL_BITS-1:0] <= shd_q.col_start;
        REG_ROW_START:  rdata_q[ROW_BITS-1:0] <= shd_q.row_start;
        REG_WIN_WIDTH:  rdata_q[DIM_BITS-1:0] <= shd_q.win_w;
        REG_WIN_HEIGHT: rdata_q[DIM_BITS-1:0] <= shd_q.win_h;
        REG_HMERGE:     rdata_q[2:0] <= 3'h1 << shd_q.hbin_sh;
        REG_VMERGE:     rdata_q[2:0] <= 3'h1 << shd_q.vbin_sh;
        REG_HSKIP:      rdata_q[2:0] <= 3'h1 << shd_q.hskip_sh;
        REG_VSKIP:      rdata_q[2:0] <= 3'h1 << shd_q.vskip_sh;
        REG_MERGE_MODE: rdata_q[1:0] <= {shd_q.vmode_avg, shd_q.hmode_avg};
        REG_MIRROR:
          rdata_q[1:0] <= {shd_q.mirror_rows, shd_q.mirror_columns};
        REG_COEF_PICK:  rdata_q[3:0] <= pick_q;
        REG_COEF_VALUE: rdata_q[8:0] <= eff_coef[pick_q];
        REG_STATUS:
        begin
          rdata_q[STAT_KIND_POS +: 2]        <= kind;
          rdata_q[STAT_BUSY_BIT]             <= (st_q != ST_IDLE);
          rdata_q[STAT_W_POS +: DIM_BITS]    <= shd_w;
          rdata_q[STAT_H_POS +: DIM_BITS]    <= shd_h;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Intake: gamma, matrix and frame store
  // ----------------------------------------------------------------
  // The frame that starts now uses the fresh settings from its first pixel
  assign cfg_use  = (st_q == ST_IDLE) ? shd_q : act_q;
  assign coef_use = (st_q == ST_IDLE) ? eff_coef : act_coef_q;

  gamma_curve u_gamma (
    .mode   (cfg_use.gamma),
    .px_in  (pix_in.data),
    .px_out (gam)
  );

  color_matrix u_matrix (
    .px_in  (gam),
    .coef   (coef_use),
    .px_out (mat)
  );

  assign proc    = cfg_use.mat_en ? mat : gam;
  assign take    = pix_in.valid && in_ready_q;
  // A halted stage ignores new frames; the frame in flight completes
  assign start   = take && pix_in.sof && (st_q == ST_IDLE) && !halt_q;
  assign wr_addr = start ? '0 : wr_idx_q;

  // Whole frame is stored so that row mirroring can read it backwards
  always_ff @(posedge clock)
  begin
    if (start || (take && st_q == ST_FILL))
      mem[wr_addr] <= proc;
  end

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  assign out_w    = act_q.win_w >> (act_q.hbin_sh + act_q.hskip_sh);
  assign out_h    = act_q.win_h >> (act_q.vbin_sh + act_q.vskip_sh);
  assign bx_last  = (bx_q == bin_last(act_q.hbin_sh));
  assign by_last  = (by_q == bin_last(act_q.vbin_sh));
  assign px_done  = bx_last && by_last;
  assign oc_last  = (oc_q == out_w - 6'h01);
  assign row_last = (orow_q == out_h - 6'h01);

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:
        if (start)
          st_d = ST_FILL;
      ST_FILL:
        if (take && wr_idx_q == LAST_PIXEL)
          st_d = (out_w == '0 || out_h == '0) ? ST_IDLE : ST_DRAIN;
      ST_DRAIN:
        if (px_done && oc_last && row_last)
          st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q       <= ST_IDLE;
      in_ready_q <= 1'b0;
      wr_idx_q   <= '0;
      act_q      <= CFG_RESET;
      act_coef_q <= COEF_IDENTITY;
    end
    else
    begin
      st_q       <= st_d;
      in_ready_q <= (st_d != ST_DRAIN);
      if (start)
      begin
        act_q      <= shd_q;
        act_coef_q <= eff_coef;
        wr_idx_q   <= 10'h001;
      end
      else if (take && st_q == ST_FILL)
        wr_idx_q <= wr_idx_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Readout: window, mirroring, binning and decimation
  // ----------------------------------------------------------------
  assign col_base = act_q.mirror_columns ? (out_w - 6'h01 - oc_q)
                                         : oc_q;
  assign row_base = act_q.mirror_rows ? (out_h - 6'h01 - orow_q)
                                      : orow_q;
  // Skipping strides over pixels, binning also visits the ones between
  assign src_col = {1'b0, act_q.col_start}
                 + (col_base << (act_q.hbin_sh + act_q.hskip_sh))
                 + {4'h0, bx_q};
  assign src_row = {1'b0, act_q.row_start}
                 + (row_base << (act_q.vbin_sh + act_q.vskip_sh))
                 + {4'h0, by_q};
  assign smp     = mem[{src_row[ROW_BITS-1:0], src_col[COL_BITS-1:0]}];
  assign avg_sh  = {1'b0, act_q.hmode_avg ? act_q.hbin_sh : 2'h0}
                 + {1'b0, act_q.vmode_avg ? act_q.vbin_sh : 2'h0};

  genvar k;
  generate
    for (k = 0; k < 3; k++)
    begin : g_comp
      logic [11:0] avg;
      assign tot[k] = acc_q[k] + {4'h0, smp[k]};
      assign avg    = tot[k] >> avg_sh;
      assign res[k] = (avg > 12'h0ff) ? 8'hff : avg[7:0];
    end
  endgenerate

  assign pattern[2] = {oc_q[4:0], 3'h0};
  assign pattern[1] = {orow_q[4:0], 3'h0};
  assign pattern[0] = {oc_q[4:1] ^ orow_q[4:1], 4'h0};

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_q   <= '0;
      orow_q <= '0;
      bx_q   <= 2'h0;
      by_q   <= 2'h0;
      acc_q  <= '0;
    end
    else if (st_q != ST_DRAIN)
    begin
      oc_q   <= '0;
      orow_q <= '0;
      bx_q   <= 2'h0;
      by_q   <= 2'h0;
      acc_q  <= '0;
    end
    else
    begin
      acc_q <= px_done ? '0 : tot;
      if (!bx_last)
        bx_q <= bx_q + 2'h1;
      else
      begin
        bx_q <= 2'h0;
        by_q <= by_last ? 2'h0 : by_q + 2'h1;
        if (by_last)
        begin
          oc_q <= oc_last ? '0 : oc_q + 6'h01;
          if (oc_last)
            orow_q <= orow_q + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      out_q <= '0;
    else
    begin
      out_q.valid <= (st_q == ST_DRAIN) && px_done;
      out_q.sof   <= (oc_q == '0) && (orow_q == '0);
      out_q.eol   <= oc_last;
      out_q.eof   <= oc_last && row_last;
      out_q.data  <= act_q.test_en ? pattern : res;
    end
  end
endmodule
`default_nettype wire

// [dv/pixfmt_props.sv]
`timescale 1ns/100ps
`default_nettype none
module pixfmt_props (
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic [7:0]           reg_addr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 in_ready,
  input wire pixfmt_pkg::out_pix_t pix_out
);
  import pixfmt_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  chk_unmapped_zero:
    assert property (reg_rd && reg_addr == 8'h3c |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold:
    assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
  chk_eof_has_eol:
    assert property (pix_out.valid && pix_out.eof |-> pix_out.eol)
    else $error("eof without eol");
  chk_eof_quiet:
    assert property (pix_out.valid && pix_out.eof |=> !pix_out.valid [*8])
    else $error("output after eof");
  logic [10:0] low_cnt_q;
  // Cycles with ready low; a full-sensor drain needs exactly 1024
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      low_cnt_q <= 11'h000;
    else if (in_ready)
      low_cnt_q <= 11'h000;
    else if (low_cnt_q != 11'h7ff)
      low_cnt_q <= low_cnt_q + 11'h001;
  end
  chk_ready_back:
    assert property (low_cnt_q <= 11'h44c)
    else $error("ready stuck low");
  chk_idle_quiet:
    assert property (in_ready && $past(in_ready) |-> !pix_out.valid)
    else $error("output while taking");
  chk_drain_busy:
    assert property (pix_out.valid && !pix_out.eof |-> !in_ready)
    else $error("ready during drain");
  chk_sof_fresh:
    assert property (pix_out.valid && pix_out.sof |-> !$past(in_ready))
    else $error("sof not after fill");
endmodule
bind pixel_format_pipeline pixfmt_props props_u (.clock(clock),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .in_ready(in_ready), .pix_out(pix_out));
`default_nettype wire

// [dv/sensor_src.sv]
`timescale 1ns/100ps
`default_nettype none
module sensor_src (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          go,
  input  wire logic          slow,
  input  wire logic          in_ready,
  output var  logic          busy,
  output var  pixfmt_pkg::in_pix_t pix
);
  import pixfmt_pkg::*;
  logic [9:0] idx_q;
  logic       ph_q;
  logic       vld;
  rgb_t       px;
  // --------------------------------------------
  // Raster source: R=col, G=row, B near full scale
  // --------------------------------------------
  assign vld = busy && (ph_q || !slow);
  assign px = {3'h0, idx_q[4:0], 3'h0, idx_q[9:5], 8'hf0};
  // Idle data is inverted so a stale value never looks valid
  assign pix = '{valid: vld, sof: vld && idx_q == 10'h000,
                 data: vld ? px : ~px};
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      ph_q <= 1'b0;
    else
      ph_q <= ~ph_q;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      idx_q <= 10'h000;
    else if (vld && in_ready)
      idx_q <= idx_q + 10'h001;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      busy <= 1'b0;
    else if (go)
      busy <= 1'b1;
    else if (vld && in_ready && idx_q == 10'h3ff)
      busy <= 1'b0;
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pixfmt_pkg::*;
  logic        clock, rst_n, reg_wr, reg_rd, go, slow, busy, in_ready;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  in_pix_t     pix_in;
  out_pix_t    pix_out;
  rgb_t        got[$];
  int          fail_count, n_compared, cyc;
  pixel_format_pipeline dut_u (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in(pix_in),
    .in_ready(in_ready), .pix_out(pix_out));
  sensor_src src_u (.clock(clock), .rst_n(rst_n), .go(go), .slow(slow),
    .in_ready(in_ready), .busy(busy), .pix(pix_in));
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ----------------------------------
  // Output capture and hang limit
  // ----------------------------------
  always @(negedge clock)
  begin
    if (pix_out.valid === 1'b1)
      got.push_back(pix_out.data);
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Both bus tasks leave a spare cycle so strobes never re-arm in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock) reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string w);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock) reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, w);
    @(posedge clock);
  endtask
  // Halt follows CTRL value c only around the frame; CTRL is set back to halt after it
  task automatic frame(input int n, input logic s, input logic [31:0] c);
    wr(REG_CTRL, c);
    got.delete();
    slow <= s;
    go <= 1'b1;
    @(posedge clock) go <= 1'b0;
    #1;
    repeat (5000) if (busy || !in_ready || got.size() < n) @(posedge clock);
    repeat (10) @(posedge clock);
    chk(got.size(), n, "pixel count");
    wr(REG_CTRL, 32'h1);
  endtask
  task automatic t_regs();
    rd(REG_CTRL, 32'h1, "ctrl reset");
    rd(REG_STATUS, 32'h00202000, "status reset");
    rd(8'h3c, 32'h0, "unmapped");
    for (int f = 1; f < 4; f++)
    begin
      wr(REG_CTRL, {26'h0, 2'(f), 4'h1});
      rd(REG_STATUS, {30'h00080800, f == 3 ? 2'h2 : 2'h1}, "kind");
    end
    wr(REG_COEF_PICK, 32'h0);
    wr(REG_COEF_VALUE, 32'h55);
    rd(REG_COEF_VALUE, 32'(COEF_LUMA_ONLY[0]), "coef mono");
    wr(REG_CTRL, 32'h1);
    rd(REG_COEF_VALUE, 32'(COEF_IDENTITY[0]), "coef locked");
    wr(REG_COEF_VALUE, 32'h55);
    rd(REG_COEF_VALUE, 32'h55, "coef user");
    wr(REG_CTRL, 32'h9);
    rd(REG_COEF_VALUE, 32'(COEF_CORRECTION[0]), "coef preset");
    wr(REG_CTRL, 32'h1);
    $display("end regs");
  endtask
  task automatic t_window();
    wr(REG_COL_START, 32'h4);
    wr(REG_ROW_START, 32'h2);
    wr(REG_WIN_WIDTH, 32'h8);
    wr(REG_WIN_HEIGHT, 32'h4);
    wr(REG_MIRROR, 32'h1);
    frame(32, 1'b1, 32'h0);
    for (int k = 0; k < 32; k++)
      chk(got[k], {8'(11 - k % 8), 8'(2 + k / 8), 8'hf0}, "win");
    $display("end window");
  endtask
  task automatic t_bin();
    wr(REG_COL_START, 32'h0);
    wr(REG_ROW_START, 32'h0);
    wr(REG_WIN_WIDTH, 32'h20);
    wr(REG_WIN_HEIGHT, 32'h20);
    wr(REG_MIRROR, 32'h0);
    wr(REG_HMERGE, 32'h2);
    wr(REG_VMERGE, 32'h2);
    wr(REG_MERGE_MODE, 32'h2);
    wr(REG_HSKIP, 32'h2);
    rd(REG_HSKIP, 32'h1, "skip blocked");
    rd(REG_STATUS, 32'h00101000, "bin size");
    frame(256, 1'b0, 32'h0);
    for (int k = 0; k < 256; k++)
      chk(got[k], {8'(4 * (k % 16) + 1), 8'(4 * (k / 16) + 1), 8'hff},
          "bin");
    $display("end bin");
  endtask
  task automatic t_skip();
    wr(REG_HMERGE, 32'h1);
    wr(REG_VMERGE, 32'h1);
    wr(REG_HSKIP, 32'h4);
    wr(REG_VSKIP, 32'h2);
    frame(128, 1'b1, 32'h0);
    for (int k = 0; k < 128; k++)
      chk(got[k], {8'(4 * (k % 8)), 8'(2 * (k / 8)), 8'hf0}, "skip");
    frame(128, 1'b0, 32'h2);
    for (int k = 0; k < 128; k++)
      chk(got[k], {8'(8 * (k % 8)), 8'(8 * (k / 8)),
          8'(((k % 8 / 2) ^ (k / 16)) * 16)}, "pattern");
    // Dark gamma, mono luma matrix and row mirroring in one frame
    wr(REG_MIRROR, 32'h2);
    frame(128, 1'b0, 32'h74);
    for (int k = 0; k < 128; k++)
    begin
      int r, g, y;
      r = (4 * (k % 8)) * (4 * (k % 8)) / 256;
      g = (30 - 2 * (k / 8)) * (30 - 2 * (k / 8)) / 256;
      y = (int'(COEF_LUMA_ONLY[0]) * r + int'(COEF_LUMA_ONLY[1]) * g
          + int'(COEF_LUMA_ONLY[2]) * (240 * 240 / 256)) >> FRAC_BITS;
      chk(got[k], {3{8'(y)}}, "luma");
    end
    frame(0, 1'b0, 32'h1);
    $display("end skip");
  endtask
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    {rst_n, reg_wr, reg_rd, go, slow, reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_regs();
    t_window();
    t_bin();
    t_skip();
    final_report();
  end
endmodule
`default_nettype wire
